// ---- core/dopz_sync2.sv ----
/*
 Two-flop synchroniser for a bundle of levels.
 Assumes each bit is a level or a toggle that stays put for several destination edges.
*/
`timescale 1ns/10ps
module dopz_sync2 #(
    parameter int W = 1
) (
    input  wire logic  clk,
    input  wire logic  reset_n,
    dopz_sync_if.stage port_if
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    always_comb begin
        meta_d = port_if.raw;
        out_d  = meta_q;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            out_q  <= '0;
        end else begin
            meta_q <= meta_d;
            out_q  <= out_d;
        end
    end

    assign port_if.synced = out_q;
endmodule : dopz_sync2

// ---- core/dopz_top.sv ----
/*
 Termination timing across precharge power-down with the DLL frozen, and the
 long/short impedance calibration engine. Link logic runs on the memory clock,
 timing of asynchronous termination and calibration on core_clk.
 Assumes the memory clock keeps running while CKE is low.
*/
// Behaviour
// - asynchronous termination path never adds additive latency
// - ODT keeps working in power-down; read/write commands there are ignored
// - asynchronous turn-on starts after 2 ns, complete by 8.5 ns
// - asynchronous turn-off starts after 2 ns, high impedance by 8.5 ns
// - entry window exists only when power-down freezes the DLL
// - entry window spans WL-1 before CKE low to tCPDED end
// - refresh in flight stretches entry window to later of tRFC, tCPDED
// - window start excluded, tCPDED or refresh end included
// - ODT rise in window: turn-on anywhere between async and sync bounds
// - ODT fall in window: turn-off anywhere between async and sync bounds
// - exit window spans WL-1 before CKE high to tXPDLL after
// - overlapping entry then exit: uncertain from entry start to exit end
// - overlapping exit then entry: uncertain from exit start to entry end
// - long calibration command starts the internal calibration engine
// - finished calibration loads new driver and termination codes into I/O
// - first long calibration gets tZQinit, later ones tZQoper
// - short calibration finishes within tZQCS of 64 clocks
// - asynchronous mode when power-down freezes the DLL
`timescale 1ns/10ps
`include "dopz_regs.svh"
module dopz_top #(
    parameter int ZQINIT_NCK  = `DOPZ_ZQINIT_NCK,
    parameter int ZQOPER_NCK  = `DOPZ_ZQOPER_NCK,
    parameter int LINK_TCK_NS = `DOPZ_LINK_TCK_NS,
    parameter int TCPDED_NCK  = `DOPZ_TCPDED_NCK,
    parameter int TXPDLL_NCK  = `DOPZ_TXPDLL_NCK
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       ck_clk,
    input  wire logic       cke,
    input  wire logic       odt,
    input  wire logic [2:0] cmd,
    input  wire logic       dll_pd_fast,
    input  wire logic [3:0] wl,
    input  wire logic [7:0] cal_code,
    output logic            rtt_on,
    output logic            rtt_uncertain,
    output logic            async_mode,
    output logic            cmd_ignored,
    output logic            zq_busy,
    output logic            zq_init_done,
    output logic [7:0]      io_code,
    output logic            io_load
);
    localparam int ZQINIT_CYC = ZQINIT_NCK * LINK_TCK_NS / `DOPZ_CORE_NS;
    localparam int ZQOPER_CYC = ZQOPER_NCK * LINK_TCK_NS / `DOPZ_CORE_NS;
    localparam int ZQCS_CYC   = `DOPZ_ZQCS_NCK * LINK_TCK_NS / `DOPZ_CORE_NS;
    localparam int RFC_NCK    = (`DOPZ_TRFC_NS + LINK_TCK_NS - 1) / LINK_TCK_NS;
    localparam logic [7:0] TC_LD = 8'(TCPDED_NCK);
    localparam logic [7:0] TX_LD = 8'(TXPDLL_NCK);

    function automatic logic is_rdwr(input logic [2:0] c);
        is_rdwr = (c == dopz_pkg::CMD_RD) || (c == dopz_pkg::CMD_WR);
    endfunction : is_rdwr

    // crossings: config into link domain, pins and link state into core domain
    dopz_sync_if #(.W(1)) cfg_if ();
    dopz_sync_if #(.W(9)) pin_if ();
    dopz_sync_if #(.W(5)) lnk_if ();

    dopz_sync2 #(.W(1)) u_cfg (.clk(ck_clk), .reset_n(reset_n), .port_if(cfg_if.stage));
    dopz_sync2 #(.W(9)) u_pin (.clk(core_clk), .reset_n(reset_n), .port_if(pin_if.stage));
    dopz_sync2 #(.W(5)) u_lnk (.clk(core_clk), .reset_n(reset_n), .port_if(lnk_if.stage));

    // link domain
    logic        cke_q, cke_d, pd_q, pd_d, win_q, win_d, async_q, async_d;
    logic        sterm_q, sterm_d, ign_q, ign_d, zqlt_q, zqlt_d, zqst_q, zqst_d;
    logic [15:0] pipe_q, pipe_d;
    logic [3:0]  look_q, look_d, pidx;
    logic [7:0]  rfc_q, rfc_d, ent_q, ent_d, ext_q, ext_d;
    logic        pd_fast_s, freeze, fall, rise, recent, cke_hi;

    assign cfg_if.raw = ~dll_pd_fast;  // inverted: a cleared chain means DLL running, no false window
    assign pd_fast_s  = ~cfg_if.synced;

    always_comb begin
        freeze = ~pd_fast_s;
        fall   = cke_q & ~cke;
        rise   = ~cke_q & cke;
        cke_hi = cke_q & cke;
        cke_d  = cke;
        pd_d   = ~cke;
        pipe_d = {pipe_q[14:0], odt};
        pidx   = (wl > 4'h4) ? wl - 4'h4 : 4'h0;
        // sync path latency WL-2; the async path below bypasses it entirely
        sterm_d = pipe_q[pidx];
        look_d  = (odt != pipe_q[0]) ? 4'h0 : ((look_q == 4'hF) ? 4'hF : look_q + 4'h1);
        recent  = look_q < (wl - 4'h1);
        rfc_d   = (rfc_q != 8'h0) ? rfc_q - 8'h1 : 8'h0;
        if (cke_hi && cmd == dopz_pkg::CMD_REF) begin
            rfc_d = 8'(RFC_NCK);
        end
        ent_d = (ent_q != 8'h0) ? ent_q - 8'h1 : 8'h0;
        if (fall && freeze) begin
            // loaded after the CKE-low edge so the last counted cycle is in
            ent_d = (rfc_q > TC_LD) ? rfc_q : TC_LD;
        end
        ext_d = (ext_q != 8'h0) ? ext_q - 8'h1 : 8'h0;
        if (rise && freeze) begin
            ext_d = TX_LD;
        end
        // union of both windows keeps overlaps continuous
        win_d   = freeze & ((ent_d != 8'h0) | (ext_d != 8'h0) | ((fall | rise) & recent));
        async_d = freeze & (pd_d | (ent_d != 8'h0) | (ext_d != 8'h0));
        // command receivers are off in power-down, ODT still sampled
        ign_d  = ~cke_q & is_rdwr(cmd);
        zqlt_d = zqlt_q ^ (cke_hi & (cmd == dopz_pkg::CMD_ZQCL));
        zqst_d = zqst_q ^ (cke_hi & (cmd == dopz_pkg::CMD_ZQCS));
    end

    always_ff @(posedge ck_clk or negedge reset_n) begin
        if (!reset_n) begin
            cke_q   <= 1'b0;
            pd_q    <= 1'b0;
            win_q   <= 1'b0;
            async_q <= 1'b0;
            sterm_q <= 1'b0;
            ign_q   <= 1'b0;
            zqlt_q  <= 1'b0;
            zqst_q  <= 1'b0;
            pipe_q  <= 16'h0000;
            look_q  <= 4'hF;
            rfc_q   <= 8'h00;
            ent_q   <= 8'h00;
            ext_q   <= 8'h00;
        end else begin
            cke_q   <= cke_d;
            pd_q    <= pd_d;
            win_q   <= win_d;
            async_q <= async_d;
            sterm_q <= sterm_d;
            ign_q   <= ign_d;
            zqlt_q  <= zqlt_d;
            zqst_q  <= zqst_d;
            pipe_q  <= pipe_d;
            look_q  <= look_d;
            rfc_q   <= rfc_d;
            ent_q   <= ent_d;
            ext_q   <= ext_d;
        end
    end

    assign cmd_ignored = ign_q;
    assign lnk_if.raw  = {async_q, sterm_q, win_q, zqlt_q, zqst_q};

    sequence s_pd_entry;
        cke_q && !cke && !pd_fast_s;
    endsequence
    sequence s_pd_exit;
        !cke_q && cke && !pd_fast_s;
    endsequence

    chk_entry_len:
    assert property (@(posedge ck_clk) disable iff (!reset_n)
        s_pd_entry |=> ent_q == (($past(rfc_q) > TC_LD) ? $past(rfc_q) : TC_LD))
        else $error("entry window length wrong");
    chk_exit_len:
    assert property (@(posedge ck_clk) disable iff (!reset_n)
        s_pd_exit |=> ext_q == TX_LD ##1 win_q)
        else $error("exit window length wrong");
    chk_window_union:
    assert property (@(posedge ck_clk) disable iff (!reset_n)
        !pd_fast_s && (ent_q > 8'h1 || ext_q > 8'h1) |=> win_q && async_q)
        else $error("window dropped while counting");
    chk_fast_nowin:
    assert property (@(posedge ck_clk) disable iff (!reset_n)
        pd_fast_s |=> !win_q && !async_q)
        else $error("window without frozen DLL");
    chk_cmd_ignore:
    assert property (@(posedge ck_clk) disable iff (!reset_n)
        pd_q && is_rdwr(cmd) |=> ign_q)
        else $error("command in power-down not ignored");

    // core domain
    logic       async_s, sterm_s, win_s, zql_s, zqs_s, odt_s, zql_ev, zqs_ev;
    logic [7:0] code_s;
    logic       rtt_q, rtt_d, tgt_q, tgt_d, unc_q, unc_d, asy_q, asy_d;
    logic       zqlp_q, zqlp_d, zqsp_q, zqsp_d, long_q, long_d, init_q, init_d;
    logic       load_q, load_d, busy_q, busy_d;
    logic [3:0] dly_q, dly_d;
    logic [19:0] cnt_q, cnt_d, bud_q, bud_d, blen_q, blen_d;
    logic [7:0] code_q, code_d;
    dopz_pkg::dopz_zq_state_t st_q, st_d;

    // the code is steady while the engine runs, so bitwise syncing is safe
    assign pin_if.raw = {odt, cal_code};
    assign {odt_s, code_s} = pin_if.synced;
    assign {async_s, sterm_s, win_s, zql_s, zqs_s} = lnk_if.synced;

    always_comb begin
        tgt_d = tgt_q;
        dly_d = (dly_q != 4'h0) ? dly_q - 4'h1 : 4'h0;
        rtt_d = rtt_q;
        if (!async_s) begin
            rtt_d = sterm_s;
            tgt_d = sterm_s;
            dly_d = 4'h0;
        end else if (odt_s != tgt_q) begin
            // no latency beyond the pad delay, whatever AL is
            tgt_d = odt_s;
            dly_d = odt_s ? 4'(`DOPZ_AON_MAX_CYC) : 4'(`DOPZ_AOF_MAX_CYC);
        end else if (dly_q == 4'h1) begin
            rtt_d = tgt_q;
        end
        // uncertainty flag lets the controller apply the widened bounds
        unc_d = win_s;
        asy_d = async_s;
    end

    assign zql_ev = zql_s ^ zqlp_q;
    assign zqs_ev = zqs_s ^ zqsp_q;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        bud_d  = bud_q;
        long_d = long_q;
        init_d = init_q;
        code_d = code_q;
        load_d = 1'b0;
        zqlp_d = zql_s;
        zqsp_d = zqs_s;
        // commands arriving while busy are dropped; the channel must be quiet
        case (st_q)
            dopz_pkg::ZQ_IDLE: begin
                if (zql_ev) begin
                    bud_d  = init_q ? 20'(ZQOPER_CYC) : 20'(ZQINIT_CYC);
                    cnt_d  = bud_d;
                    long_d = 1'b1;
                    st_d   = dopz_pkg::ZQ_CAL;
                end else if (zqs_ev) begin
                    bud_d  = 20'(ZQCS_CYC);
                    cnt_d  = bud_d;
                    long_d = 1'b0;
                    st_d   = dopz_pkg::ZQ_CAL;
                end
            end
            dopz_pkg::ZQ_CAL: begin
                cnt_d = cnt_q - 20'h1;
                if (cnt_q <= 20'h1) begin
                    st_d = dopz_pkg::ZQ_LOAD;
                end
            end
            dopz_pkg::ZQ_LOAD: begin
                code_d = code_s;
                load_d = 1'b1;
                init_d = init_q | long_q;
                st_d   = dopz_pkg::ZQ_IDLE;
            end
            default: begin
                st_d = dopz_pkg::ZQ_IDLE;
            end
        endcase
        busy_d = (st_d != dopz_pkg::ZQ_IDLE);
        blen_d = busy_q ? blen_q + 20'h1 : 20'h0;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rtt_q  <= 1'b0;
            tgt_q  <= 1'b0;
            dly_q  <= 4'h0;
            unc_q  <= 1'b0;
            asy_q  <= 1'b0;
            zqlp_q <= 1'b0;
            zqsp_q <= 1'b0;
            st_q   <= dopz_pkg::ZQ_IDLE;
            cnt_q  <= 20'h00000;
            bud_q  <= 20'h00000;
            blen_q <= 20'h00000;
            long_q <= 1'b0;
            init_q <= 1'b0;
            code_q <= `DOPZ_CODE_RST;
            load_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            rtt_q  <= rtt_d;
            tgt_q  <= tgt_d;
            dly_q  <= dly_d;
            unc_q  <= unc_d;
            asy_q  <= asy_d;
            zqlp_q <= zqlp_d;
            zqsp_q <= zqsp_d;
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            bud_q  <= bud_d;
            blen_q <= blen_d;
            long_q <= long_d;
            init_q <= init_d;
            code_q <= code_d;
            load_q <= load_d;
            busy_q <= busy_d;
        end
    end

    assign rtt_on        = rtt_q;
    assign rtt_uncertain = unc_q;
    assign async_mode    = asy_q;
    assign zq_busy       = busy_q;
    assign zq_init_done  = init_q;
    assign io_code       = code_q;
    assign io_load       = load_q;

    sequence s_async_change;
        async_s && $changed(odt_s);
    endsequence

    // two cycles is the max delay count plus the target register
    chk_async_follow:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        s_async_change ##1 async_s [*2] |-> rtt_q == $past(odt_s, 2))
        else $error("async termination late or wrong");
    chk_async_early:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        $stable(odt_s) ##1 s_async_change ##1 async_s |-> $stable(rtt_q))
        else $error("async termination changed too early");
    chk_zq_first:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        st_q == dopz_pkg::ZQ_IDLE && zql_ev && !init_q
        |=> bud_q == 20'(ZQINIT_CYC) && busy_q)
        else $error("first long calibration budget wrong");
    chk_zqcs_budget:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        st_q == dopz_pkg::ZQ_IDLE && zqs_ev && !zql_ev |=> bud_q == 20'(ZQCS_CYC))
        else $error("short calibration budget wrong");
    chk_zq_len:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(busy_q) |-> blen_q == bud_q + 20'h1)
        else $error("calibration busy length wrong");
    chk_zq_load:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(busy_q) |-> load_q && io_code == $past(code_s) ##1 !load_q)
        else $error("calibration result not loaded");
    chk_init_flag:
    assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(init_q) |-> $fell(busy_q) && long_q)
        else $error("init flag set without long calibration");
endmodule : dopz_top

// ---- shared/dopz_pkg.sv ----
/*
 Types shared by the termination and calibration block.
 Assumes nothing beyond the header of constants.
*/
package dopz_pkg;
    typedef enum logic [2:0] {
        CMD_NOP  = 3'h0,
        CMD_REF  = 3'h1,
        CMD_ZQCL = 3'h2,
        CMD_ZQCS = 3'h3,
        CMD_RD   = 3'h4,
        CMD_WR   = 3'h5
    } dopz_cmd_t;

    typedef enum logic [2:0] {
        ZQ_IDLE = 3'h1,
        ZQ_CAL  = 3'h2,
        ZQ_LOAD = 3'h4
    } dopz_zq_state_t;
endpackage : dopz_pkg

// ---- shared/dopz_regs.svh ----
/*
 Timing figures and reset values for the termination and calibration block.
 Assumes the core clock period given here; the asynchronous delay counts are derived from the printed times.
*/
`ifndef DOPZ_REGS_SVH
`define DOPZ_REGS_SVH

`define DOPZ_CORE_PS        8000
`define DOPZ_CORE_NS        8
`define DOPZ_TAONPD_MIN_PS  2000
`define DOPZ_TAONPD_MAX_PS  8500
`define DOPZ_TAOFPD_MIN_PS  2000
`define DOPZ_TAOFPD_MAX_PS  8500
`define DOPZ_AON_MIN_CYC    ((`DOPZ_TAONPD_MIN_PS + `DOPZ_CORE_PS - 1) / `DOPZ_CORE_PS)
`define DOPZ_AON_MAX_CYC    (`DOPZ_TAONPD_MAX_PS / `DOPZ_CORE_PS)
`define DOPZ_AOF_MIN_CYC    ((`DOPZ_TAOFPD_MIN_PS + `DOPZ_CORE_PS - 1) / `DOPZ_CORE_PS)
`define DOPZ_AOF_MAX_CYC    (`DOPZ_TAOFPD_MAX_PS / `DOPZ_CORE_PS)
`define DOPZ_ZQCS_NCK       64
`define DOPZ_ZQINIT_NCK     512
`define DOPZ_ZQOPER_NCK     256
`define DOPZ_LINK_TCK_NS    80
`define DOPZ_TRFC_NS        260
`define DOPZ_TCPDED_NCK     1
`define DOPZ_TXPDLL_NCK     10
`define DOPZ_ODT_PIPE       16
`define DOPZ_CODE_W         8
`define DOPZ_CODE_RST       8'h80

`endif

// ---- shared/dopz_sync_if.sv ----
/*
 Carrier between a domain and a two-stage synchroniser.
 Assumes the receiving side reads only the synced bundle.
*/
`timescale 1ns/10ps
interface dopz_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport sender (output raw, input synced);
    modport stage  (input raw, output synced);
endinterface : dopz_sync_if

// ---- verif/dopz_ctl_model.sv ----
/*
 Memory controller model on the link side of the termination and calibration block.
 Assumes ck_clk runs free; every pin changes just after a falling ck_clk edge.
*/
`timescale 1ns/10ps
module dopz_ctl_model (
    input  wire logic       ck_clk,
    output logic            cke,
    output logic            odt,
    output logic [2:0]      cmd
);
    initial begin
        cke = 1'b1;
        odt = 1'b0;
        cmd = dopz_pkg::CMD_NOP;
    end

    // one command per ck cycle, then back to nop so the channel stays quiet
    // the model never opens a row, so banks are always precharged before calibration
    task automatic issue(input logic [2:0] c);
        @(negedge ck_clk);
        cmd = c;
        @(negedge ck_clk);
        cmd = dopz_pkg::CMD_NOP;
    endtask : issue

    // power-down is entered and left only through cke, never with reads or writes
    // unless a scenario asks for a refused access
    task automatic pins(input logic k, input logic o);
        @(negedge ck_clk);
        cke = k;
        odt = o;
    endtask : pins

    task automatic tick(input int n);
        repeat (n) @(negedge ck_clk);
    endtask : tick
endmodule : dopz_ctl_model

// ---- verif/tb_top.sv ----
/*
 Self-checking bench for the termination and calibration block.
 Assumes the controller model drives the link and shortened long calibration counts; the short one keeps 64 clocks.
*/
`timescale 1ns/10ps
module tb_top;
    localparam int ZQI = 8;
    localparam int ZQO = 4;
    localparam int TXP = 10;
    localparam int CPL = 10;

    logic       core_clk;
    logic       ck_clk;
    logic       reset_n;
    logic       cke;
    logic       odt;
    logic [2:0] cmd;
    logic       dll_pd_fast;
    logic [3:0] wl;
    logic [7:0] cal_code;
    logic       rtt_on;
    logic       rtt_uncertain;
    logic       async_mode;
    logic       cmd_ignored;
    logic       zq_busy;
    logic       zq_init_done;
    logic [7:0] io_code;
    logic       io_load;
    int         errors;
    int         checked;
    int         cyc;
    int         ck_half = 37;
    int         len;
    int         plain;
    bit         first_zq;
    logic [7:0] exp_code[$];

    dopz_top #(.ZQINIT_NCK(ZQI), .ZQOPER_NCK(ZQO), .LINK_TCK_NS(80),
               .TCPDED_NCK(1), .TXPDLL_NCK(TXP)) u_dut (
        .core_clk(core_clk), .reset_n(reset_n), .ck_clk(ck_clk), .cke(cke),
        .odt(odt), .cmd(cmd), .dll_pd_fast(dll_pd_fast), .wl(wl),
        .cal_code(cal_code), .rtt_on(rtt_on), .rtt_uncertain(rtt_uncertain),
        .async_mode(async_mode), .cmd_ignored(cmd_ignored), .zq_busy(zq_busy),
        .zq_init_done(zq_init_done), .io_code(io_code), .io_load(io_load)
    );

    dopz_ctl_model u_ctl (.ck_clk(ck_clk), .cke(cke), .odt(odt), .cmd(cmd));

    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;
    initial ck_clk = 1'b0;
    // first half period shortened so link edges never meet core edges
    always #(ck_half) begin
        ck_clk = ~ck_clk;
        ck_half = 40;
    end

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : check

    task automatic print_verdict;
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // cut a hang short well past the longest expected run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            print_verdict();
        end
    end

    // one calibration; the model picks the budget from the command and, for a long one, the first-call flag
    task automatic zq_run(input logic [2:0] c);
        int budget;
        int total;
        total = 0;
        budget = (c == dopz_pkg::CMD_ZQCS) ? 64 : (first_zq ? ZQI : ZQO);
        @(negedge core_clk);
        cal_code = 8'($urandom);
        exp_code.push_back(cal_code);
        // counting starts before the command lands, busy rises before issue returns
        fork
            u_ctl.issue(c);
            begin
                for (int i = 0; i < 2000; i++) begin
                    @(negedge core_clk);
                    if (zq_busy === 1'b1) begin
                        total++;
                    end else if (total > 0) begin
                        break;
                    end
                end
            end
        join
        check("zq_busy_cycles", budget * CPL + 1, total);
        check("io_load", 1'b1, io_load);
        check("io_code", exp_code.pop_front(), io_code);
        if (c == dopz_pkg::CMD_ZQCL) begin
            first_zq = 1'b0;
        end
        @(negedge core_clk);
        check("io_load_end", 1'b0, io_load);
        check("zq_init_done", 1'b1, zq_init_done);
    endtask : zq_run

    // length of the next uncertainty span in core cycles, zero if none shows
    task automatic win_len(output int n);
        n = 0;
        for (int i = 0; i < 400; i++) begin
            @(negedge core_clk);
            if (rtt_uncertain === 1'b1) begin
                n++;
            end else if (n > 0 || i > 60) begin
                break;
            end
        end
    endtask : win_len

    // asynchronous turn-on and turn-off; wl is large so any added latency shows
    task automatic odt_async(input logic v);
        int lat;
        lat = 0;
        u_ctl.pins(1'b0, v);
        @(negedge core_clk);
        check("rtt_hold", !v, rtt_on);
        while (rtt_on !== v && lat < 12) begin
            @(negedge core_clk);
            lat++;
        end
        check("rtt_async_lat", 1'b1, lat >= 1 && lat <= 6);
    endtask : odt_async

    initial begin
        reset_n = 1'b0;
        dll_pd_fast = 1'b1;
        wl = 4'h9;
        cal_code = 8'h00;
        errors = 0;
        checked = 0;
        cyc = 0;
        first_zq = 1'b1;
        void'($urandom(89));
        // reset is asynchronous, so both domains clear without link edges
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        u_ctl.tick(4);
        check("io_code_rst", 8'h80, io_code);
        check("zq_init_done_rst", 1'b0, zq_init_done);
        check("async_mode_rst", 1'b0, async_mode);
        check("rtt_on_rst", 1'b0, rtt_on);
        zq_run(dopz_pkg::CMD_ZQCL);
        zq_run(dopz_pkg::CMD_ZQCL);
        zq_run(dopz_pkg::CMD_ZQCS);
        // dll kept running in power-down: no window, no asynchronous mode
        u_ctl.pins(1'b0, 1'b0);
        win_len(len);
        check("fast_win", 0, len);
        check("fast_async", 1'b0, async_mode);
        u_ctl.pins(1'b1, 1'b0);
        @(negedge core_clk);
        dll_pd_fast = 1'b0;
        u_ctl.tick(4);
        u_ctl.pins(1'b0, 1'b0);
        win_len(plain);
        check("entry_win", 1'b1, plain >= 4 && plain <= 24);
        check("async_mode", 1'b1, async_mode);
        odt_async(1'b1);
        odt_async(1'b0);
        // the flag stands for the ck cycle after the refused command only
        for (int k = 0; k < 2; k++) begin
            u_ctl.issue(k ? dopz_pkg::CMD_WR : dopz_pkg::CMD_RD);
            check("cmd_ignored", 1'b1, cmd_ignored);
            @(negedge ck_clk);
            check("cmd_ignored_end", 1'b0, cmd_ignored);
        end
        u_ctl.issue(dopz_pkg::CMD_ZQCS);
        repeat (20) @(negedge core_clk);
        check("zq_in_pd", 1'b0, zq_busy);
        u_ctl.pins(1'b1, 1'b0);
        win_len(len);
        check("exit_win", 1'b1, len >= TXP * CPL - 10 && len <= TXP * CPL + 25);
        check("async_left", 1'b0, async_mode);
        // refresh still running at cke fall stretches the entry span
        u_ctl.issue(dopz_pkg::CMD_REF);
        u_ctl.pins(1'b0, 1'b0);
        win_len(len);
        check("ref_win", 1'b1, len > plain + 15);
        // power-down exit, then short idle before re-entry: one joined span
        u_ctl.pins(1'b1, 1'b0);
        u_ctl.tick(3);
        u_ctl.pins(1'b0, 1'b0);
        win_len(len);
        check("overlap_win", 1'b1, len >= TXP * CPL - 50);
        check("async_again", 1'b1, async_mode);
        u_ctl.pins(1'b1, 1'b0);
        win_len(len);
        check("exit_win2", 1'b1, len >= TXP * CPL - 10);
        print_verdict();
    end
endmodule : tb_top
